//--- sba_asserts.sv
`timescale 1ns/1ps
module sba_asserts (
   input wire logic                       clk,
   input wire logic                       resetn,
   input wire logic                       ce1_n,
   input wire logic                       ce2,
   input wire logic                       ce3_n,
   input wire logic                       clock_gate_n,
   input wire logic                       advance_or_load,
   input wire logic                       we_n,
   input wire logic                       oe_n,
   input wire logic                       sleep_request,
   input wire logic [sba_pkg::DATA_W-1:0] dq_from_mem,
   input wire logic                       dq_mem_oe,
   input wire logic                       dq_ctl_oe
);
   // ************************************************************
   // Cycle decode
   // ************************************************************
   logic ce_off;
   logic load;
   assign ce_off = ce1_n | !ce2 | ce3_n;
   assign load   = !clock_gate_n && !advance_or_load;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   // ************************************************************
   // Checks
   // ************************************************************
   AST_DESEL_FLOAT: assert property (load && ce_off |=> !dq_mem_oe)
      else $error("bus driven after deselect");
   AST_SUSPEND_HOLD: assert property (clock_gate_n |=> $stable(dq_from_mem))
      else $error("read data changed on gated edge");
   // Sleep history keeps the synchroniser out of the picture
   AST_READ_DRIVE: assert property ((!sleep_request)[*3] ##0 (load && !ce_off && we_n)
      |=> (dq_mem_oe || oe_n))
      else $error("read not driven");
   AST_WRITE_FLOAT: assert property (load && !ce_off && !we_n |=> !dq_mem_oe)
      else $error("bus driven in write data cycle");
   AST_CTL_WDATA: assert property (load && !ce_off && !we_n |=> dq_ctl_oe)
      else $error("write data not presented");
   AST_OE_GATE: assert property (oe_n |-> !dq_mem_oe)
      else $error("driving with output enable off");
   AST_RESET_FLOAT: assert property ($rose(resetn) |-> !dq_mem_oe)
      else $error("driving after reset");
   AST_SLEEP_FLOAT: assert property (sleep_request[*3] |-> !dq_mem_oe)
      else $error("driving while asleep");
   AST_SLEEP_DESEL: assert property ($rose(sleep_request) |-> ce_off)
      else $error("sleep requested while selected");
   AST_SLEEP_REC: assert property ($fell(sleep_request) |-> ce_off[*2])
      else $error("selected during sleep recovery");

   COV_READ: cover property (load && !ce_off && we_n);
   COV_WRITE: cover property (load && !ce_off && !we_n);
   COV_SUSPEND: cover property (clock_gate_n[*2]);
   COV_SLEEP: cover property ($fell(sleep_request));
endmodule

//--- sba_ctl.sv
`timescale 1ns/1ps
module sba_ctl (
   input  wire logic                       clk,
   input  wire logic                       resetn,
   sba_if.ctl                              bus,
   input  wire logic                       cmd_valid,
   output logic                            cmd_ready,
   input  wire logic                       cmd_write,
   input  wire logic                       cmd_cont,
   input  wire logic [sba_pkg::ADDR_W-1:0] cmd_addr,
   input  wire logic [sba_pkg::DATA_W-1:0] cmd_wdata,
   input  wire logic [sba_pkg::BWS_W-1:0]  cmd_bws_n,
   input  wire logic                       cfg_interleave,
   input  wire logic                       pause,
   input  wire logic                       sleep_in,
   output logic                            rsp_valid,
   output logic [sba_pkg::DATA_W-1:0]      rsp_rdata,
   output logic                            sleeping
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [sba_pkg::ADDR_W-1:0] addr;
      logic                       ce_off;
      logic                       cg_n;
      logic                       adv;
      logic                       we_n;
      logic [sba_pkg::BWS_W-1:0]  bws_n;
      logic                       zz;
      logic                       order;
      logic                       is_rd;
      logic                       is_wr;
      logic [sba_pkg::DATA_W-1:0] wstage;
      logic [sba_pkg::DATA_W-1:0] dq_out;
      logic                       dq_oe;
      logic                       rd_wait;
      logic                       rsp_v;
      logic [sba_pkg::DATA_W-1:0] rsp_d;
      sba_pkg::sba_kind_t         bkind;
      sba_pkg::sba_cst_t          st;
      logic [1:0]                 rec;
      logic                       rdy;
   } sba_ctl_t;

   sba_ctl_t q;
   sba_ctl_t d;
   logic     act;
   logic     issue;

   assign act   = !q.cg_n;
   assign issue = cmd_valid && q.rdy;

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb
   begin
      d        = q;
      d.order  = cfg_interleave;
      d.rsp_v  = q.rd_wait;
      // Read data stands from the taking edge to the next taken edge
      if (q.rd_wait)
      begin
         d.rsp_d = bus.dq;
      end
      d.rd_wait = act && q.is_rd;
      if (act)
      begin
         d.dq_oe  = q.is_wr;
         d.dq_out = q.wstage;
      end
      if (issue)
      begin
         d.wstage = cmd_wdata;
         d.bws_n  = cmd_bws_n;
         if (cmd_cont)
         begin
            d.adv   = 1'b1;
            d.is_rd = (q.bkind == sba_pkg::SBA_READ);
            d.is_wr = (q.bkind == sba_pkg::SBA_WRITE);
         end
         else
         begin
            d.addr   = cmd_addr;
            d.adv    = 1'b0;
            d.ce_off = 1'b0;
            d.we_n   = !cmd_write;
            d.is_rd  = !cmd_write;
            d.is_wr  = cmd_write;
            d.bkind  = cmd_write ? sba_pkg::SBA_WRITE : sba_pkg::SBA_READ;
         end
      end
      else if (act)
      begin
         d.adv    = 1'b0;
         d.ce_off = 1'b1;
         d.is_rd  = 1'b0;
         d.is_wr  = 1'b0;
         d.bkind  = sba_pkg::SBA_IDLE;
      end
      d.cg_n = pause;
      unique case (q.st)
         sba_pkg::SBA_RUN:
         begin
            if (sleep_in)
            begin
               d.st = sba_pkg::SBA_DESEL;
            end
         end
         sba_pkg::SBA_DESEL:
         begin
            d.cg_n = 1'b0;
            if (act && q.ce_off && !q.adv && !q.is_rd && !q.is_wr)
            begin
               d.st = sba_pkg::SBA_SLEEP;
               d.zz = 1'b1;
            end
         end
         sba_pkg::SBA_SLEEP:
         begin
            d.cg_n = 1'b0;
            if (!sleep_in)
            begin
               d.zz  = 1'b0;
               d.rec = '0;
               d.st  = sba_pkg::SBA_RECOVER;
            end
         end
         sba_pkg::SBA_RECOVER:
         begin
            d.cg_n = 1'b0;
            d.rec  = 2'(q.rec + 2'h1);
            if (q.rec == sba_pkg::REC_LAST)
            begin
               d.st = sba_pkg::SBA_RUN;
            end
         end
      endcase
      // Nothing issued outside running; read results then in flight still complete and are returned
      d.rdy = (d.st == sba_pkg::SBA_RUN) && !sleep_in;
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         q        <= '0;
         q.addr   <= sba_pkg::RST_ADDR;
         q.ce_off <= 1'b1;
         q.bws_n  <= sba_pkg::RST_BWS_N;
         q.we_n   <= 1'b1;
         q.bkind  <= sba_pkg::SBA_IDLE;
         q.st     <= sba_pkg::SBA_RUN;
      end
      else
      begin
         q <= d;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign bus.addr               = q.addr;
   assign bus.ce1_n              = q.ce_off;
   assign bus.ce2                = !q.ce_off;
   assign bus.ce3_n              = q.ce_off;
   assign bus.clock_gate_n       = q.cg_n;
   assign bus.advance_or_load    = q.adv;
   assign bus.we_n               = q.we_n;
   assign bus.byte_write_selects = q.bws_n;
   assign bus.oe_n               = q.dq_oe;
   assign bus.burst_order        = q.order;
   assign bus.sleep_request      = q.zz;
   assign bus.dq_from_ctl        = q.dq_out;
   assign bus.dq_ctl_oe          = q.dq_oe;
   assign cmd_ready              = q.rdy;
   assign rsp_valid              = q.rsp_v;
   assign rsp_rdata              = q.rsp_d;
   assign sleeping               = (q.st == sba_pkg::SBA_SLEEP);

endmodule

//--- sba_if.sv
`timescale 1ns/1ps
interface sba_if;
   logic [sba_pkg::ADDR_W-1:0] addr;
   logic                       ce1_n;
   logic                       ce2;
   logic                       ce3_n;
   logic                       clock_gate_n;
   logic                       advance_or_load;
   logic                       we_n;
   logic [sba_pkg::BWS_W-1:0]  byte_write_selects;
   logic                       oe_n;
   logic                       burst_order;
   logic                       sleep_request;
   logic [sba_pkg::DATA_W-1:0] dq_from_ctl;
   logic                       dq_ctl_oe;
   logic [sba_pkg::DATA_W-1:0] dq_from_mem;
   logic                       dq_mem_oe;
   logic [sba_pkg::DATA_W-1:0] dq;

   // Undriven bus reads as all ones, like a weak pull-up
   assign dq = dq_mem_oe ? dq_from_mem : (dq_ctl_oe ? dq_from_ctl : '1);

   modport mem (input addr, ce1_n, ce2, ce3_n, clock_gate_n, advance_or_load, we_n, byte_write_selects,
                oe_n, burst_order, sleep_request, dq, output dq_from_mem, dq_mem_oe);
   modport ctl (output addr, ce1_n, ce2, ce3_n, clock_gate_n, advance_or_load, we_n, byte_write_selects,
                oe_n, burst_order, sleep_request, dq_from_ctl, dq_ctl_oe, input dq);
endinterface

//--- sba_mem.sv
`timescale 1ns/1ps
module sba_mem #(
   parameter bit ORG_X18 = 1'b0
) (
   input  wire logic clk,
   input  wire logic resetn,
   sba_if.mem        bus,
   output logic      asleep,
   output logic      burst_active
);

   // ************************************************************
   // State
   // ************************************************************
   logic [sba_pkg::DATA_W-1:0] mem [0:sba_pkg::MEM_DEPTH-1];

   sba_pkg::sba_kind_t         kind;
   sba_pkg::sba_kind_t         next_kind;
   logic [sba_pkg::ADDR_W-1:0] base;
   logic [sba_pkg::ADDR_W-1:0] next_base;
   logic [1:0]                 cnt;
   logic [1:0]                 next_cnt;
   logic                       rd_drive;
   logic                       next_rd_drive;
   logic [sba_pkg::DATA_W-1:0] rd_data;
   logic [sba_pkg::DATA_W-1:0] next_rd_data;
   logic                       wr_pend;
   logic                       next_wr_pend;
   logic [sba_pkg::WIDX_W-1:0] wr_idx;
   logic [sba_pkg::WIDX_W-1:0] next_wr_idx;
   logic [sba_pkg::DATA_W-1:0] wr_mask;
   logic [sba_pkg::DATA_W-1:0] next_wr_mask;
   logic                       sync1;
   logic                       sync2;

   logic                       ce_all;
   logic                       commit;
   logic                       acc;
   logic                       acc_wr;
   logic [sba_pkg::ADDR_W-1:0] acc_addr;
   logic [sba_pkg::WIDX_W-1:0] acc_idx;
   logic [sba_pkg::DATA_W-1:0] wdata_al;
   logic [sba_pkg::DATA_W-1:0] wr_word;
   logic [sba_pkg::DATA_W-1:0] word;
   logic [sba_pkg::DATA_W-1:0] sel_mask;

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic [sba_pkg::WIDX_W-1:0] widx(input logic [sba_pkg::ADDR_W-1:0] a);
      return ORG_X18 ? a[sba_pkg::ADDR_W-1:1] : a[sba_pkg::WIDX_W-1:0];
   endfunction

   // Narrow words share one stored word; low address bit picks the half
   function automatic logic [sba_pkg::DATA_W-1:0] place_mask(input logic [sba_pkg::DATA_W-1:0] m,
                                                           input logic                       hi);
      return (ORG_X18 && hi) ? {m[sba_pkg::HALF_W-1:0], 18'h00000} : m;
   endfunction

   assign ce_all   = !bus.ce1_n && bus.ce2 && !bus.ce3_n;
   assign wdata_al = ORG_X18 ? {2{bus.dq[sba_pkg::HALF_W-1:0]}} : bus.dq;
   assign wr_word  = (mem[wr_idx] & ~wr_mask) | (wdata_al & wr_mask);

   // ************************************************************
   // Sleep request synchroniser
   // ************************************************************
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
      end
      else
      begin
         sync1 <= bus.sleep_request;
         sync2 <= sync1;
      end
   end

   // ************************************************************
   // Cycle decode and burst control
   // ************************************************************
   always_comb
   begin
      next_kind     = kind;
      next_base     = base;
      next_cnt      = cnt;
      next_rd_drive = rd_drive;
      next_rd_data  = rd_data;
      next_wr_pend  = wr_pend;
      next_wr_idx   = wr_idx;
      next_wr_mask  = wr_mask;
      commit        = 1'b0;
      acc           = 1'b0;
      acc_wr        = 1'b0;
      acc_addr      = base;
      acc_idx       = widx(base);
      word          = sba_pkg::RST_DATA;
      sel_mask      = sba_pkg::lane_mask(bus.byte_write_selects, ORG_X18);
      if (sync2)
      begin
         // Pending work is dropped; stored words are untouched
         next_kind     = sba_pkg::SBA_IDLE;
         next_rd_drive = 1'b0;
         next_wr_pend  = 1'b0;
      end
      else if (!bus.clock_gate_n)
      begin
         commit = wr_pend;
         if (!bus.advance_or_load)
         begin
            if (ce_all)
            begin
               next_base = bus.addr;
               next_cnt  = sba_pkg::RST_CNT;
               next_kind = bus.we_n ? sba_pkg::SBA_READ : sba_pkg::SBA_WRITE;
               acc       = 1'b1;
               acc_wr    = !bus.we_n;
               acc_addr  = bus.addr;
            end
            else
            begin
               next_kind = sba_pkg::SBA_IDLE;
            end
         end
         else if (kind != sba_pkg::SBA_IDLE)
         begin
            // Chip enables and write strobe are not looked at here
            next_cnt = 2'(cnt + 2'h1);
            acc      = 1'b1;
            acc_wr   = (kind == sba_pkg::SBA_WRITE);
            acc_addr = {base[sba_pkg::ADDR_W-1:sba_pkg::LOW_BITS],
                        sba_pkg::burst_low(base[1:0], next_cnt, bus.burst_order)};
         end
         acc_idx = widx(acc_addr);
         word    = mem[acc_idx];
         // Forward the write committing on this edge to a read of the same word
         if (commit && wr_idx == acc_idx)
         begin
            word = wr_word;
         end
         next_rd_drive = acc && !acc_wr;
         if (acc && !acc_wr)
         begin
            if (ORG_X18)
            begin
               next_rd_data = acc_addr[0] ? {18'h00000, word[sba_pkg::DATA_W-1:sba_pkg::HALF_W]}
                                          : {18'h00000, word[sba_pkg::HALF_W-1:0]};
            end
            else
            begin
               next_rd_data = word;
            end
         end
         next_wr_pend = acc && acc_wr;
         if (acc && acc_wr)
         begin
            next_wr_idx  = acc_idx;
            next_wr_mask = place_mask(sel_mask, acc_addr[0]);
         end
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         kind     <= sba_pkg::SBA_IDLE;
         base     <= sba_pkg::RST_ADDR;
         cnt      <= sba_pkg::RST_CNT;
         rd_drive <= 1'b0;
         rd_data  <= sba_pkg::RST_DATA;
         wr_pend  <= 1'b0;
         wr_idx   <= '0;
         wr_mask  <= sba_pkg::RST_DATA;
      end
      else
      begin
         kind     <= next_kind;
         base     <= next_base;
         cnt      <= next_cnt;
         rd_drive <= next_rd_drive;
         rd_data  <= next_rd_data;
         wr_pend  <= next_wr_pend;
         wr_idx   <= next_wr_idx;
         wr_mask  <= next_wr_mask;
      end
   end

   // ************************************************************
   // Storage
   // ************************************************************
   // No reset on the array; a gated or sleeping edge never writes
   always_ff @(posedge clk)
   begin
      if (commit)
      begin
         mem[wr_idx] <= wr_word;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   // Output enable acts without the clock, so this gate is not registered
   assign bus.dq_mem_oe   = rd_drive && !bus.oe_n;
   assign bus.dq_from_mem = rd_data;
   assign asleep          = sync2;
   assign burst_active    = (kind != sba_pkg::SBA_IDLE);

endmodule

//--- sba_pkg.sv
package sba_pkg;

   // ************************************************************
   // Widths and layout
   // ************************************************************
   localparam int ADDR_W     = 21;
   localparam int DATA_W     = 36;
   localparam int BWS_W      = 4;
   localparam int WIDX_W     = 20;
   localparam int MEM_DEPTH  = 1 << WIDX_W;
   localparam int BYTE_W     = 8;
   localparam int HALF_W     = 18;
   localparam int PAR36_BASE = 32;
   localparam int PAR18_BASE = 16;
   localparam int LOW_BITS   = 2;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [ADDR_W-1:0] RST_ADDR  = 21'h000000;
   localparam logic [DATA_W-1:0] RST_DATA  = 36'h000000000;
   localparam logic [BWS_W-1:0]  RST_BWS_N = 4'hF;
   localparam logic [1:0]        RST_CNT   = 2'h0;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_PERIOD_PS    = 5000;
   localparam int SLEEP_ENTRY_TCYC = 2;
   localparam int SLEEP_REC_TCYC   = 2;
   localparam int SLEEP_ENTRY_CYC  = (SLEEP_ENTRY_TCYC * CLK_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SLEEP_REC_CYC    = (SLEEP_REC_TCYC * CLK_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [1:0] REC_LAST = 2'(SLEEP_REC_CYC - 1);

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [1:0] {SBA_IDLE, SBA_READ, SBA_WRITE} sba_kind_t;
   typedef enum logic [1:0] {SBA_RUN, SBA_DESEL, SBA_SLEEP, SBA_RECOVER} sba_cst_t;

   // ************************************************************
   // Functions
   // ************************************************************
   function automatic logic [DATA_W-1:0] lane_mask(input logic [BWS_W-1:0] bws_n, input logic x18);
      logic [DATA_W-1:0] m;
      m = '0;
      for (int i = 0; i < BWS_W; i++)
      begin
         if (!bws_n[i] && (!x18 || i < 2))
         begin
            m[i*BYTE_W +: BYTE_W] = '1;
            m[(x18 ? PAR18_BASE : PAR36_BASE) + i] = 1'b1;
         end
      end
      return m;
   endfunction

   function automatic logic [1:0] burst_low(input logic [1:0] start, input logic [1:0] cnt, input logic ilv);
      return ilv ? (start ^ cnt) : 2'(start + cnt);
   endfunction

endpackage

//--- sync_burst_sram_access_control_tb_top.sv
`timescale 1ns/1ps
module sync_burst_sram_access_control_tb_top;
   logic                       clk;
   logic                       resetn;
   logic                       cmd_valid;
   logic                       cmd_ready;
   logic                       cmd_write;
   logic                       cmd_cont;
   logic [sba_pkg::ADDR_W-1:0] cmd_addr;
   logic [sba_pkg::DATA_W-1:0] cmd_wdata;
   logic [sba_pkg::BWS_W-1:0]  cmd_bws_n;
   logic                       cfg_interleave;
   logic                       pause;
   logic                       sleep_in;
   logic                       rsp_valid;
   logic [sba_pkg::DATA_W-1:0] rsp_rdata;
   logic                       sleeping;
   logic                       asleep;
   logic                       burst_active;
   logic [sba_pkg::DATA_W-1:0] rq[$];
   int                         n_fail;
   int                         n_tests;

   sba_if bus();
   sba_mem i_sba_mem (.clk(clk), .resetn(resetn), .bus(bus), .asleep(asleep), .burst_active(burst_active));
   sba_ctl i_sba_ctl (.clk(clk), .resetn(resetn), .bus(bus), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_write(cmd_write), .cmd_cont(cmd_cont), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
      .cmd_bws_n(cmd_bws_n), .cfg_interleave(cfg_interleave), .pause(pause), .sleep_in(sleep_in),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .sleeping(sleeping));
   sba_asserts i_sba_asserts (.clk(clk), .resetn(resetn), .ce1_n(bus.ce1_n), .ce2(bus.ce2),
      .ce3_n(bus.ce3_n), .clock_gate_n(bus.clock_gate_n), .advance_or_load(bus.advance_or_load),
      .we_n(bus.we_n), .oe_n(bus.oe_n), .sleep_request(bus.sleep_request), .dq_from_mem(bus.dq_from_mem),
      .dq_mem_oe(bus.dq_mem_oe), .dq_ctl_oe(bus.dq_ctl_oe));

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
      n_tests++;
      if (got !== exp)
      begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         n_fail++;
      end
   endtask

   // Leaves valid high so back-to-back beats need no second assignment
   task automatic cmd(input logic w, input logic c, input logic [20:0] a, input logic [35:0] d,
                      input logic [3:0] b);
      int k;
      k = 0;
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_cont <= c;
      cmd_addr <= a;
      cmd_wdata <= d;
      cmd_bws_n <= b;
      @(negedge clk);
      while (cmd_ready !== 1'b1 && k < 60)
      begin
         @(negedge clk);
         k++;
      end
      if (k == 60)
         n_fail++;
      @(posedge clk);
   endtask

   task automatic got(input int n);
      int k;
      k = 0;
      while (rq.size() < n && k < 60)
      begin
         @(posedge clk);
         k++;
      end
   endtask

   task automatic pop_chk(input logic [35:0] exp);
      got(1);
      chk("read data", exp, rq.size() > 0 ? rq.pop_front() : 36'h000000000);
   endtask

   task automatic wr(input logic [20:0] a, input logic [35:0] d, input logic [3:0] b);
      cmd(1'b1, 1'b0, a, d, b);
      cmd_valid <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [20:0] a, input logic [35:0] exp);
      cmd(1'b0, 1'b0, a, 36'h000000000, 4'hF);
      cmd_valid <= 1'b0;
      pop_chk(exp);
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_lanes;
      logic [35:0] e;
      for (int i = 0; i < 5; i++)
      begin
         e = 36'hFFFFFFFFF;
         if (i < 4)
         begin
            e[8*i +: 8] = 8'h00;
            e[32+i] = 1'b0;
         end
         wr(21'h000200 + 21'(4*i), 36'hFFFFFFFFF, 4'h0);
         wr(21'h000200 + 21'(4*i), 36'h000000000, 4'(~(5'h01 << i)));
         rd(21'h000200 + 21'(4*i), e);
      end
      $display("test lanes done");
   endtask

   task automatic t_burst(input logic o, input logic [1:0] s);
      logic [20:0] a;
      a = 21'h000100;
      cfg_interleave <= o;
      @(posedge clk);
      for (int n = 0; n < 4; n++)
         cmd(1'b1, n != 0, a | 21'(s), 36'h5A5A00000 + 36'(16*o + n), 4'h0);
      cmd_valid <= 1'b0;
      @(posedge clk);
      for (int n = 0; n < 4; n++)
         rd(a | 21'(o ? 2'(s ^ n) : 2'(s + n)), 36'h5A5A00000 + 36'(16*o + n));
      for (int n = 0; n < 4; n++)
      begin
         // Gate the edge that takes beat one; an idle edge would close the burst
         if (n == 1)
            pause <= 1'b1;
         cmd(1'b0, n != 0, a | 21'(s), 36'h000000000, 4'hF);
         if (n == 1)
         begin
            cmd_valid <= 1'b0;
            repeat (3) @(posedge clk);
            chk("burst open", 36'h000000001, 36'(burst_active));
            pause <= 1'b0;
            @(posedge clk);
         end
      end
      cmd_valid <= 1'b0;
      for (int n = 0; n < 4; n++)
         pop_chk(36'h5A5A00000 + 36'(16*o + n));
      $display("test burst done");
   endtask

   task automatic t_sleep;
      int k;
      k = 0;
      wr(21'h000300, 36'h9C3A5E7D1, 4'h0);
      sleep_in <= 1'b1;
      while (sleeping !== 1'b1 && k < 20)
      begin
         @(posedge clk);
         k++;
      end
      repeat (4) @(posedge clk);
      chk("asleep", 36'h000000001, 36'(asleep));
      chk("drive", 36'h000000000, 36'(bus.dq_mem_oe));
      chk("sleeping", 36'h000000001, 36'(sleeping));
      chk("burst idle", 36'h000000000, 36'(burst_active));
      sleep_in <= 1'b0;
      @(posedge clk);
      rd(21'h000300, 36'h9C3A5E7D1);
      $display("test sleep done");
   endtask

   // ************************************************************
   // Clock, reset, sequence
   // ************************************************************
   always @(posedge clk)
      if (rsp_valid === 1'b1)
         rq.push_back(rsp_rdata);

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Whole run needs well under two thousand cycles
   initial
   begin
      #20000;
      n_fail++;
      tally_and_finish;
   end

   initial
   begin
      n_fail = 0;
      n_tests = 0;
      resetn = 1'b0;
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_cont = 1'b0;
      cmd_addr = 21'h000000;
      cmd_wdata = 36'h000000000;
      cmd_bws_n = 4'hF;
      cfg_interleave = 1'b0;
      pause = 1'b0;
      sleep_in = 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      repeat (2) @(posedge clk);
      t_lanes;
      t_burst(1'b0, 2'h1);
      t_burst(1'b1, 2'h2);
      t_sleep;
      tally_and_finish;
   end
endmodule
